// ===== design/gpx_pin_control.sv
// gpio bank pin control: registers, pin drive, edge events and interrupt
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_control (
    input  wire logic                      clk,
    input  wire logic                      reset,
    input  wire gpx_pkg::gpx_reg_req_t     regReq,
    output gpx_pkg::gpx_reg_rsp_t          regRsp,
    input  wire logic [gpx_pkg::LINES-1:0] pinIn,
    output logic      [gpx_pkg::LINES-1:0] pinOut,
    output logic      [gpx_pkg::LINES-1:0] pinOutEnN,
    output logic                           irqOutN
);

    localparam gpx_pkg::gpx_state_t STATE_RESET = '{
        openDrainA: gpx_pkg::RESET_ZERO,
        polarity:   {gpx_pkg::RESET_ZERO, gpx_pkg::RESET_ZERO},
        direction:  {gpx_pkg::RESET_ONES, gpx_pkg::RESET_ONES},
        pinValue:   {gpx_pkg::RESET_ONES, gpx_pkg::RESET_ONES},
        irqMask:    {gpx_pkg::RESET_ONES, gpx_pkg::RESET_ONES},
        edgeSelect: {gpx_pkg::RESET_ZERO, gpx_pkg::RESET_ZERO,
                     gpx_pkg::RESET_ZERO, gpx_pkg::RESET_ZERO},
        eventFlags: '0,
        irqSource:  '0,
        prevLevel:  '0,
        pins:       '{level: '0, driveEnN: '1},
        irqOutN:    1'b1,
        rsp:        '{valid: 1'b0, rdata: gpx_pkg::RESET_ZERO}
    };

    gpx_pkg::gpx_state_t           state_reg;
    gpx_pkg::gpx_state_t           state_next;
    logic [gpx_pkg::LINES-1:0]     pinSync;

    gpx_pin_sync u_sync (
        .clk     (clk),
        .reset   (reset),
        .pinIn   (pinIn),
        .pinSync (pinSync)
    );

    always_comb
    begin : next_state
        logic [gpx_pkg::LINES-1:0]               polFlat;
        logic [gpx_pkg::LINES-1:0]               dirFlat;
        logic [gpx_pkg::LINES-1:0]               valFlat;
        logic [gpx_pkg::LINES-1:0]               maskFlat;
        logic [gpx_pkg::LINES-1:0]               level;
        logic [gpx_pkg::LINES-1:0]               driveVal;
        logic [gpx_pkg::LINES-1:0]               hit;
        logic [gpx_pkg::LINES-1:0]               clearFlags;
        logic [gpx_pkg::LINES-1:0]               senseChanged;
        logic [gpx_pkg::SENSE_BYTES*gpx_pkg::BYTE_W-1:0] oldSense;
        logic [gpx_pkg::SENSE_BYTES*gpx_pkg::BYTE_W-1:0] newSense;
        logic                                    odLine;
        gpx_pkg::gpx_edge_t                      sel;
        logic [7:0]                              rdata;

        state_next   = state_reg;
        polFlat      = state_reg.polarity;
        dirFlat      = state_reg.direction;
        valFlat      = state_reg.pinValue;
        maskFlat     = state_reg.irqMask;
        level        = '0;
        driveVal     = '0;
        hit          = '0;
        clearFlags   = '0;
        senseChanged = '0;
        oldSense     = state_reg.edgeSelect;
        newSense     = state_reg.edgeSelect;
        odLine       = 1'b0;
        sel          = gpx_pkg::EDGE_NONE;
        rdata        = gpx_pkg::READ_UNMAPPED;

        // polarity-adjusted view of the synchronised pins
        level    = pinSync ^ polFlat;
        // written bit is inverted on its way to the pin where its polarity bit is set
        driveVal = valFlat ^ polFlat;

        // register writes
        if (regReq.write)
        begin
            unique case (regReq.addr)
                gpx_pkg::ADDR_OPEN_DRAIN_A:
                begin
                    state_next.openDrainA = regReq.wdata;
                end
                gpx_pkg::ADDR_POLARITY_B:
                begin
                    state_next.polarity[gpx_pkg::BANK_B] = regReq.wdata;
                end
                gpx_pkg::ADDR_POLARITY_A:
                begin
                    state_next.polarity[gpx_pkg::BANK_A] = regReq.wdata;
                end
                gpx_pkg::ADDR_DIRECTION_B:
                begin
                    state_next.direction[gpx_pkg::BANK_B] = regReq.wdata;
                end
                gpx_pkg::ADDR_DIRECTION_A:
                begin
                    state_next.direction[gpx_pkg::BANK_A] = regReq.wdata;
                end
                gpx_pkg::ADDR_PIN_VALUE_B:
                begin
                    state_next.pinValue[gpx_pkg::BANK_B] = regReq.wdata;
                end
                gpx_pkg::ADDR_PIN_VALUE_A:
                begin
                    state_next.pinValue[gpx_pkg::BANK_A] = regReq.wdata;
                end
                gpx_pkg::ADDR_IRQ_MASK_B:
                begin
                    state_next.irqMask[gpx_pkg::BANK_B] = regReq.wdata;
                end
                gpx_pkg::ADDR_IRQ_MASK_A:
                begin
                    state_next.irqMask[gpx_pkg::BANK_A] = regReq.wdata;
                end
                gpx_pkg::ADDR_EDGE_15_12:
                begin
                    state_next.edgeSelect[gpx_pkg::SENSE_IDX_15_12] =
                        regReq.wdata;
                end
                gpx_pkg::ADDR_EDGE_11_8:
                begin
                    state_next.edgeSelect[gpx_pkg::SENSE_IDX_11_8] =
                        regReq.wdata;
                end
                gpx_pkg::ADDR_EDGE_7_4:
                begin
                    state_next.edgeSelect[gpx_pkg::SENSE_IDX_7_4] =
                        regReq.wdata;
                end
                gpx_pkg::ADDR_EDGE_3_0:
                begin
                    state_next.edgeSelect[gpx_pkg::SENSE_IDX_3_0] =
                        regReq.wdata;
                end
                // source and event registers are write-one-to-clear
                gpx_pkg::ADDR_IRQ_SOURCE_B,
                gpx_pkg::ADDR_EVENT_B:
                begin
                    clearFlags[gpx_pkg::BYTE_W +: gpx_pkg::BYTE_W] =
                        regReq.wdata;
                end
                gpx_pkg::ADDR_IRQ_SOURCE_A,
                gpx_pkg::ADDR_EVENT_A:
                begin
                    clearFlags[0 +: gpx_pkg::BYTE_W] = regReq.wdata;
                end
                default:
                begin
                    // unmapped write is dropped
                end
            endcase
        end
        newSense = state_next.edgeSelect;

        // per-line edge detection, event flags and pin drive
        for (int i = 0; i < gpx_pkg::LINES; i++)
        begin
            sel = gpx_pkg::gpx_edge_t'(oldSense[2*i +: 2]);
            unique case (sel)
                gpx_pkg::EDGE_NONE:
                begin
                    hit[i] = 1'b0;
                end
                gpx_pkg::EDGE_RISE:
                begin
                    hit[i] = level[i] & ~state_reg.prevLevel[i];
                end
                gpx_pkg::EDGE_FALL:
                begin
                    hit[i] = ~level[i] & state_reg.prevLevel[i];
                end
                gpx_pkg::EDGE_BOTH:
                begin
                    hit[i] = level[i] ^ state_reg.prevLevel[i];
                end
            endcase

            // new edge field clears the line's event flag
            senseChanged[i] = |(oldSense[2*i +: 2] ^ newSense[2*i +: 2]);

            // open drain exists on bank A only
            odLine = (i < gpx_pkg::BYTE_W)
                     ? state_reg.openDrainA[i % gpx_pkg::BYTE_W]
                                           : 1'b0;
            if (!dirFlat[i])
            begin
                state_next.pins.level[i] = driveVal[i];
                // open drain floats the pin for a high level
                state_next.pins.driveEnN[i] = odLine & driveVal[i];
            end
            else
            begin
                // inputs are never driven
                state_next.pins.level[i]    = 1'b0;
                state_next.pins.driveEnN[i] = 1'b1;
            end
        end

        // set wins over clear, so no edge is lost to a clear
        state_next.eventFlags = (state_reg.eventFlags
                                 & ~clearFlags & ~senseChanged)
                                | hit;
        // only unmasked input lines reach the interrupt
        state_next.irqSource = (state_reg.irqSource & ~clearFlags)
                               | (hit & ~maskFlat & dirFlat);
        state_next.prevLevel = level;
        state_next.irqOutN   = ~|state_next.irqSource;

        // read answer one cycle after the request
        if (regReq.read)
        begin
            unique case (regReq.addr)
                gpx_pkg::ADDR_OPEN_DRAIN_A:
                begin
                    rdata = state_reg.openDrainA;
                end
                gpx_pkg::ADDR_POLARITY_B:
                begin
                    rdata = state_reg.polarity[gpx_pkg::BANK_B];
                end
                gpx_pkg::ADDR_POLARITY_A:
                begin
                    rdata = state_reg.polarity[gpx_pkg::BANK_A];
                end
                gpx_pkg::ADDR_DIRECTION_B:
                begin
                    rdata = state_reg.direction[gpx_pkg::BANK_B];
                end
                gpx_pkg::ADDR_DIRECTION_A:
                begin
                    rdata = state_reg.direction[gpx_pkg::BANK_A];
                end
                // pin level, not the written value, whatever the direction
                gpx_pkg::ADDR_PIN_VALUE_B:
                begin
                    rdata = level[gpx_pkg::BYTE_W +: gpx_pkg::BYTE_W];
                end
                gpx_pkg::ADDR_PIN_VALUE_A:
                begin
                    rdata = level[0 +: gpx_pkg::BYTE_W];
                end
                gpx_pkg::ADDR_IRQ_MASK_B:
                begin
                    rdata = state_reg.irqMask[gpx_pkg::BANK_B];
                end
                gpx_pkg::ADDR_IRQ_MASK_A:
                begin
                    rdata = state_reg.irqMask[gpx_pkg::BANK_A];
                end
                gpx_pkg::ADDR_EDGE_15_12:
                begin
                    rdata = state_reg.edgeSelect[gpx_pkg::SENSE_IDX_15_12];
                end
                gpx_pkg::ADDR_EDGE_11_8:
                begin
                    rdata = state_reg.edgeSelect[gpx_pkg::SENSE_IDX_11_8];
                end
                gpx_pkg::ADDR_EDGE_7_4:
                begin
                    rdata = state_reg.edgeSelect[gpx_pkg::SENSE_IDX_7_4];
                end
                gpx_pkg::ADDR_EDGE_3_0:
                begin
                    rdata = state_reg.edgeSelect[gpx_pkg::SENSE_IDX_3_0];
                end
                gpx_pkg::ADDR_IRQ_SOURCE_B:
                begin
                    rdata = state_reg.irqSource[gpx_pkg::BYTE_W +:
                                                gpx_pkg::BYTE_W];
                end
                gpx_pkg::ADDR_IRQ_SOURCE_A:
                begin
                    rdata = state_reg.irqSource[0 +: gpx_pkg::BYTE_W];
                end
                gpx_pkg::ADDR_EVENT_B:
                begin
                    rdata = state_reg.eventFlags[gpx_pkg::BYTE_W +:
                                                 gpx_pkg::BYTE_W];
                end
                gpx_pkg::ADDR_EVENT_A:
                begin
                    rdata = state_reg.eventFlags[0 +: gpx_pkg::BYTE_W];
                end
                default:
                begin
                    rdata = gpx_pkg::READ_UNMAPPED;
                end
            endcase
        end
        state_next.rsp.valid = regReq.read;
        state_next.rsp.rdata = regReq.read ? rdata : gpx_pkg::READ_UNMAPPED;
    end

    // reset values come from the register table
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign regRsp    = state_reg.rsp;
    assign pinOut    = state_reg.pins.level;
    assign pinOutEnN = state_reg.pins.driveEnN;
    assign irqOutN   = state_reg.irqOutN;

endmodule
`default_nettype wire

// ===== design/gpx_pin_sync.sv
// two flip-flop synchroniser for the sixteen pin inputs
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_sync (
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire logic [gpx_pkg::LINES-1:0] pinIn,
    output logic      [gpx_pkg::LINES-1:0] pinSync
);

    gpx_pkg::gpx_sync_state_t state_reg;
    gpx_pkg::gpx_sync_state_t state_next;

    // first stage feeds only the second stage
    always_comb
    begin
        state_next        = state_reg;
        state_next.stage1 = pinIn;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pinSync = state_reg.stage2;

endmodule
`default_nettype wire

// ===== design/gpx_pkg.sv
// constants, types and register map for the gpio bank pin control block
package gpx_pkg;

    localparam int LINES  = 16;
    localparam int BYTE_W = 8;
    localparam int BANKS  = 2;
    localparam int SENSE_BYTES = 4;
    localparam int LINES_PER_SENSE = 4;

    // bank index inside the [1:0][7:0] storage
    localparam logic BANK_A = 1'b0;
    localparam logic BANK_B = 1'b1;

    localparam logic [7:0] ADDR_OPEN_DRAIN_A = 8'h0B;
    localparam logic [7:0] ADDR_POLARITY_B   = 8'h0C;
    localparam logic [7:0] ADDR_POLARITY_A   = 8'h0D;
    localparam logic [7:0] ADDR_DIRECTION_B  = 8'h0E;
    localparam logic [7:0] ADDR_DIRECTION_A  = 8'h0F;
    localparam logic [7:0] ADDR_PIN_VALUE_B  = 8'h10;
    localparam logic [7:0] ADDR_PIN_VALUE_A  = 8'h11;
    localparam logic [7:0] ADDR_IRQ_MASK_B   = 8'h12;
    localparam logic [7:0] ADDR_IRQ_MASK_A   = 8'h13;
    localparam logic [7:0] ADDR_EDGE_15_12   = 8'h14;
    localparam logic [7:0] ADDR_EDGE_11_8    = 8'h15;
    localparam logic [7:0] ADDR_EDGE_7_4     = 8'h16;
    localparam logic [7:0] ADDR_EDGE_3_0     = 8'h17;
    localparam logic [7:0] ADDR_IRQ_SOURCE_B = 8'h18;
    localparam logic [7:0] ADDR_IRQ_SOURCE_A = 8'h19;
    localparam logic [7:0] ADDR_EVENT_B      = 8'h1A;
    localparam logic [7:0] ADDR_EVENT_A      = 8'h1B;

    // index of each edge register in the sense storage
    localparam logic [1:0] SENSE_IDX_3_0   = 2'h0;
    localparam logic [1:0] SENSE_IDX_7_4   = 2'h1;
    localparam logic [1:0] SENSE_IDX_11_8  = 2'h2;
    localparam logic [1:0] SENSE_IDX_15_12 = 2'h3;

    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_ONES = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } gpx_edge_t;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gpx_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
    } gpx_reg_rsp_t;

    typedef struct packed {
        logic [LINES-1:0] level;
        logic [LINES-1:0] driveEnN;
    } gpx_pins_t;

    typedef struct packed {
        logic [LINES-1:0] stage1;
        logic [LINES-1:0] stage2;
    } gpx_sync_state_t;

    typedef struct packed {
        logic [BYTE_W-1:0]                      openDrainA;
        logic [BANKS-1:0][BYTE_W-1:0]           polarity;
        logic [BANKS-1:0][BYTE_W-1:0]           direction;
        logic [BANKS-1:0][BYTE_W-1:0]           pinValue;
        logic [BANKS-1:0][BYTE_W-1:0]           irqMask;
        logic [SENSE_BYTES-1:0][BYTE_W-1:0]     edgeSelect;
        logic [LINES-1:0]                       eventFlags;
        logic [LINES-1:0]                       irqSource;
        logic [LINES-1:0]                       prevLevel;
        gpx_pins_t                              pins;
        logic                                   irqOutN;
        gpx_reg_rsp_t                           rsp;
    } gpx_state_t;

endpackage

// ===== sim/gpx_pin_control_assertions.sv
// assertion checker for the gpio bank pin control block
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_control_assertions (
    input wire logic                      clk,
    input wire logic                      reset,
    input wire gpx_pkg::gpx_reg_req_t     regReq,
    input wire gpx_pkg::gpx_reg_rsp_t     regRsp,
    input wire logic [gpx_pkg::LINES-1:0] pinIn,
    input wire logic [gpx_pkg::LINES-1:0] pinOut,
    input wire logic [gpx_pkg::LINES-1:0] pinOutEnN,
    input wire logic                      irqOutN
);
    logic [7:0]  odA_reg;
    logic [15:0] pol_reg;
    logic [15:0] dir_reg;
    logic [15:0] val_reg;
    logic [15:0] msk_reg;
    logic [31:0] edg_reg;
    logic [15:0] lvl;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // shadow copy of the config, rebuilt from the write traffic alone
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            odA_reg <= 8'h00;
            pol_reg <= 16'h0000;
            dir_reg <= 16'hFFFF;
            val_reg <= 16'hFFFF;
            msk_reg <= 16'hFFFF;
            edg_reg <= 32'h00000000;
        end
        else if (regReq.write)
        begin
            case (regReq.addr)
                8'h0B: odA_reg <= regReq.wdata;
                8'h0C: pol_reg[15:8] <= regReq.wdata;
                8'h0D: pol_reg[7:0] <= regReq.wdata;
                8'h0E: dir_reg[15:8] <= regReq.wdata;
                8'h0F: dir_reg[7:0] <= regReq.wdata;
                8'h10: val_reg[15:8] <= regReq.wdata;
                8'h11: val_reg[7:0] <= regReq.wdata;
                8'h12: msk_reg[15:8] <= regReq.wdata;
                8'h13: msk_reg[7:0] <= regReq.wdata;
                8'h14: edg_reg[31:24] <= regReq.wdata;
                8'h15: edg_reg[23:16] <= regReq.wdata;
                8'h16: edg_reg[15:8] <= regReq.wdata;
                8'h17: edg_reg[7:0] <= regReq.wdata;
                default: ;
            endcase
        end
    end

    assign lvl = val_reg ^ pol_reg;

    chk_read_answer: assert property (
        regReq.read |=> regRsp.valid)
        else $error("read not answered next cycle");
    chk_no_stray: assert property (
        !regReq.read |=> !regRsp.valid)
        else $error("answer without a read");
    chk_idle_rdata: assert property (
        !regRsp.valid |-> regRsp.rdata == 8'h00)
        else $error("read data not zero when idle");
    chk_reset_outputs: assert property (
        $fell(reset) |-> pinOutEnN == 16'hFFFF && irqOutN)
        else $error("lines driven or irq low after reset");
    // two quiet cycles let the registered drive catch up with a write
    chk_drive_b_level: assert property (
        !regReq.write [*2] |-> pinOut[15:8] == (~dir_reg[15:8] & lvl[15:8]))
        else $error("bank B drive level wrong");
    chk_drive_b_enable: assert property (
        !regReq.write [*2] |-> pinOutEnN[15:8] == dir_reg[15:8])
        else $error("bank B enable wrong");
    chk_drive_a_enable: assert property (
        !regReq.write [*2]
        |-> pinOutEnN[7:0] == (dir_reg[7:0] | (odA_reg & lvl[7:0])))
        else $error("bank A enable wrong");
    chk_irq_needs_mask: assert property (
        $fell(irqOutN) |-> (msk_reg | ~dir_reg) != 16'hFFFF)
        else $error("irq fell with every input masked");
    chk_irq_needs_edge: assert property (
        $fell(irqOutN) |-> edg_reg != 32'h00000000)
        else $error("irq fell with no edge selected");

    cov_irq_fell: cover property ($fell(irqOutN));
    cov_irq_rose: cover property ($rose(irqOutN));
    cov_read_ones: cover property (regRsp.valid && regRsp.rdata != 8'h00);
endmodule

bind gpx_pin_control gpx_pin_control_assertions i_gpx_pin_control_assertions (
    .clk(clk), .reset(reset), .regReq(regReq), .regRsp(regRsp),
    .pinIn(pinIn), .pinOut(pinOut), .pinOutEnN(pinOutEnN),
    .irqOutN(irqOutN));
`default_nettype wire

// ===== sim/gpx_pin_control_test.sv
// self-checking bench for the gpio bank pin control block
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_control_test;
    logic                  clk;
    logic                  reset;
    gpx_pkg::gpx_reg_req_t regReq;
    gpx_pkg::gpx_reg_rsp_t regRsp;
    logic [15:0]           pinIn;
    logic [15:0]           pinOut;
    logic [15:0]           pinOutEnN;
    logic                  irqOutN;
    logic [15:0]           extLevel;
    logic [15:0]           rnd;
    logic [15:0]           dir;
    logic [15:0]           val;
    logic [15:0]           pol;
    logic [7:0]            od;
    logic [7:0]            rd;
    logic [7:0]            exp;
    logic [1:0]            mode;
    int                    mismatches;
    int                    checks;

    gpx_pin_control i_gpx_pin_control (.clk(clk), .reset(reset),
        .regReq(regReq), .regRsp(regRsp), .pinIn(pinIn), .pinOut(pinOut),
        .pinOutEnN(pinOutEnN), .irqOutN(irqOutN));
    gpx_pin_partner i_gpx_pin_partner (.pinOut(pinOut),
        .pinOutEnN(pinOutEnN), .extLevel(extLevel), .pinIn(pinIn));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [15:0] draw();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction

    function automatic logic [15:0] drvExp();
        return ~dir & ~({8'h00, od} & (val ^ pol));
    endfunction

    function automatic logic [15:0] pinExp();
        return ((drvExp() & (val ^ pol)) | (~drvExp() & extLevel)) ^ pol;
    endfunction

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] got);
        checks++;
        if (got !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '0;
    endtask

    task automatic rdreg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '0;
        #1;
        while (regRsp.valid !== 1'b1 && n < 4)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (regRsp.valid !== 1'b1)
        begin
            mismatches++;
            $display("BAD read valid expected 1 seen 0");
            tally_and_finish();
        end
        else
            rd = regRsp.rdata;
    endtask

    task automatic checkPins;
        logic [15:0] pin;
        repeat (4) @(posedge clk);
        pin = pinExp();
        cmp("pin enable", ~drvExp(), pinOutEnN);
        rdreg(gpx_pkg::ADDR_PIN_VALUE_B);
        cmp("data B", {8'h00, pin[15:8]}, {8'h00, rd});
        rdreg(gpx_pkg::ADDR_PIN_VALUE_A);
        cmp("data A", {8'h00, pin[7:0]}, {8'h00, rd});
    endtask

    initial
    begin
        reset = 1'b1;
        regReq = '0;
        extLevel = 16'h5A3C;
        rnd = 16'h4C31;
        {dir, val, pol, od} = {16'hFFFF, 16'hFFFF, 16'h0000, 8'h00};
        mismatches = 0;
        checks = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        for (int a = 11; a < 24; a++)
        begin
            rdreg(8'(a));
            exp = (a == 14 || a == 15 || a == 18 || a == 19) ? 8'hFF : 8'h00;
            if (a == 16 || a == 17)
                exp = 8'(pinExp() >> (a == 16 ? 8 : 0));
            cmp("reset value", {8'h00, exp}, {8'h00, rd});
        end
        dir[15:8] = 8'h00;
        wr(gpx_pkg::ADDR_DIRECTION_B, 8'h00);
        checkPins();
        // bank B has no open-drain register, so this must be dropped
        wr(8'h0A, 8'hFF);
        rdreg(8'h0A);
        cmp("unmapped", 16'h0000, {8'h00, rd});
        $display("test reset done");
        for (int i = 0; i < 20; i++)
        begin
            dir = draw();
            val = draw();
            pol = draw();
            od = 8'(draw());
            extLevel <= draw();
            wr(gpx_pkg::ADDR_DIRECTION_B, dir[15:8]);
            wr(gpx_pkg::ADDR_DIRECTION_A, dir[7:0]);
            wr(gpx_pkg::ADDR_POLARITY_B, pol[15:8]);
            wr(gpx_pkg::ADDR_POLARITY_A, pol[7:0]);
            wr(gpx_pkg::ADDR_PIN_VALUE_B, val[15:8]);
            wr(gpx_pkg::ADDR_PIN_VALUE_A, val[7:0]);
            wr(gpx_pkg::ADDR_OPEN_DRAIN_A, od);
            checkPins();
        end
        rdreg(gpx_pkg::ADDR_EVENT_A);
        cmp("no edge selected", 16'h0000, {8'h00, rd});
        $display("test random pins done");
        extLevel <= 16'h0000;
        wr(gpx_pkg::ADDR_DIRECTION_A, 8'hFF);
        wr(gpx_pkg::ADDR_POLARITY_A, 8'h00);
        wr(gpx_pkg::ADDR_IRQ_MASK_A, 8'h00);
        for (int m = 0; m < 5; m++)
        begin
            if (m == 4)
                wr(gpx_pkg::ADDR_IRQ_MASK_A, 8'hFF);
            mode = 2'(m) | {1'b0, m == 4};
            wr(gpx_pkg::ADDR_EDGE_3_0, {6'h00, mode});
            wr(gpx_pkg::ADDR_IRQ_SOURCE_A, 8'hFF);
            extLevel[0] <= 1'b1;
            repeat (6) @(posedge clk);
            rdreg(gpx_pkg::ADDR_EVENT_A);
            cmp("rise event", {15'h0000, mode[0]}, {8'h00, rd});
            cmp("rise irq", {15'h0000, !(mode[0] && m < 4)},
                {15'h0000, irqOutN});
            wr(gpx_pkg::ADDR_IRQ_SOURCE_A, 8'h01);
            @(posedge clk);
            #1;
            cmp("irq cleared", 16'h0001, {15'h0000, irqOutN});
            extLevel[0] <= 1'b0;
            repeat (6) @(posedge clk);
            rdreg(gpx_pkg::ADDR_EVENT_A);
            cmp("fall event", {15'h0000, mode[1]}, {8'h00, rd});
            wr(gpx_pkg::ADDR_EDGE_3_0, 8'h00);
            rdreg(gpx_pkg::ADDR_EVENT_A);
            cmp("edge change", 16'h0000, {8'h00, rd});
        end
        $display("test edges done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== sim/gpx_pin_partner.sv
// far-side pin logic: resolves each line from device and outside drive
`timescale 1ns/100ps
`default_nettype none
module gpx_pin_partner (
    input  wire logic [15:0] pinOut,
    input  wire logic [15:0] pinOutEnN,
    input  wire logic [15:0] extLevel,
    output logic      [15:0] pinIn
);
    // a released line, open-drain high included, follows the outside
    assign pinIn = (pinOutEnN & extLevel) | (~pinOutEnN & pinOut);
endmodule
`default_nettype wire
